// file: verilog/sps_slave.sv
`timescale 1ns/1ps
`include "sps_defines.svh"

// Behaviour
// R1: strap decode picks SPI 4-wire, SPI 3-wire, reserved or two-wire port.
// R2: two-wire slave address follows the strap, 0x2C down to 0x28.
// R3: serial chip-select input is ignored in two-wire mode.
// R4: bus traffic is ignored for 15 ms after power-up.
// R5: the clock line is never driven; master stretching is tolerated.
// R6: start is data falling while clock high, repeated start included.
// R7: first byte is 7-bit address plus direction, 1 means read.
// R8: bytes are eight bits, most significant bit first, both ways.
// R9: every received byte is acknowledged in the ninth clock slot.
// R10: host acks each read byte except the last, which it nacks.
// R11: stop while clock high returns the slave to idle.
// R12: with timeout enabled, clock low for 30 ms resets the port.
// R13: with timeout enabled, bus idle over 200 us resets the slave.
// R14: serial clock from 10 kHz to 400 kHz is supported.
// R15: block transfers carry no count byte, any length either way.
// R16: write byte stores data at the register address before stop.
// R17: read byte keeps pointer across repeated start and returns data.
// R18: a lone written byte only loads the pointer.
// R19: read without address phase returns register at current pointer.
// R20: pointer-only forms are not relied on during deep sleep.
// R21: block write stores at pointer then increments, wrapping to 00h.
// R22: block read returns consecutive registers until host nacks.
// R23: unmatched address is not acknowledged; rest of frame ignored.
// R24: outside two-wire mode the data line is never driven.
module sps_slave
   import sps_pkg::*;
#(
   parameter int unsigned POWERUP_CYC = `SPS_POWERUP_CYC,
   parameter int unsigned CLKLOW_CYC  = `SPS_CLKLOW_CYC,
   parameter int unsigned IDLE_CYC    = `SPS_IDLE_CYC
) (
   // clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rstn_i,
   // strap and configuration
   input  wire logic [2:0] protocol_strap_input_i,
   input  wire logic       timeout_en_i,
   input  wire logic       deepest_sleep_flag_i,
   input  wire logic       spi_cs_n_i,
   // two-wire bus pins
   input  wire logic       twowire_clock_pin_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   // status
   output logic [1:0]      proto_sel_o,
   output logic            ready_o,
   output logic            busy_o,
   output logic [7:0]      ptr_o,
   // register write notification
   output logic            reg_wr_o,
   output logic [7:0]      reg_waddr_o,
   output logic [7:0]      reg_wdata_o
);

   // ==========================================================
   // decode functions
   function automatic sps_proto_type proto_of(input logic [2:0] s);
      case (sps_strap_type'(s))
         STRAP_GND: proto_of = PROTO_SPI4;
         STRAP_56K: proto_of = PROTO_SPI3;
         STRAP_68K: proto_of = PROTO_RSVD;
         default:   proto_of = PROTO_TWOWIRE;
      endcase
   endfunction

   function automatic logic [6:0] addr_of(input logic [2:0] s);
      case (sps_strap_type'(s))
         STRAP_82K:  addr_of = `SPS_SADDR_82K;
         STRAP_100K: addr_of = `SPS_SADDR_100K;
         STRAP_120K: addr_of = `SPS_SADDR_120K;
         STRAP_150K: addr_of = `SPS_SADDR_150K;
         STRAP_VDD:  addr_of = `SPS_SADDR_VDD;
         default:    addr_of = `SPS_SADDR_NONE;
      endcase
   endfunction

   // ==========================================================
   // reset release and pin synchronisers
   logic [1:0] rst_sync_q;
   logic       rst_n;
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic [2:0] strap_s1_q;
   logic [2:0] strap_s2_q;
   logic       scl_p_q;
   logic       sda_p_q;

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         strap_s1_q <= 3'h0;
         strap_s2_q <= 3'h0;
         scl_p_q    <= 1'b1;
         sda_p_q    <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], twowire_clock_pin_i};
         sda_sync_q <= {sda_sync_q[0], sda_i};
         strap_s1_q <= protocol_strap_input_i;
         strap_s2_q <= strap_s1_q;
         scl_p_q    <= scl_sync_q[1];
         sda_p_q    <= sda_sync_q[1];
      end
   end

   // ==========================================================
   // strap capture shortly after reset release, during the power-up hold-off
   logic [2:0]           strap_q;
   logic                 strap_vld_q;
   logic [1:0]           proto_q;
   logic                 ready_q;
   logic [`SPS_CNT_W-1:0] pwr_cnt_q;
   logic                 pwr_done;

   assign pwr_done = pwr_cnt_q == `SPS_CNT_W'(POWERUP_CYC - 1);

   // capture waits two edges so the strap synchroniser has settled
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         strap_q     <= 3'h0;
         strap_vld_q <= 1'b0;
         proto_q     <= PROTO_RSVD;
         pwr_cnt_q   <= '0;
         ready_q     <= 1'b0;
      end else begin
         if (!strap_vld_q && pwr_cnt_q[1]) begin
            strap_q     <= strap_s2_q;
            strap_vld_q <= 1'b1;
            proto_q     <= proto_of(strap_s2_q); // R1
         end
         if (!ready_q) begin
            pwr_cnt_q <= pwr_cnt_q + `SPS_CNT_W'(1);
            ready_q   <= pwr_done; // R4
         end
      end
   end

   // ==========================================================
   // bus events
   logic       scl_s;
   logic       sda_s;
   logic       twowire_sel;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   logic [6:0] my_addr;

   assign scl_s       = scl_sync_q[1];
   assign sda_s       = sda_sync_q[1];
   // chip-select pin plays no part in two-wire operation
   assign twowire_sel = strap_vld_q && (proto_q == PROTO_TWOWIRE); // R3 R24
   assign my_addr     = addr_of(strap_q); // R2
   assign scl_rise    = scl_s && !scl_p_q; // R14
   assign scl_fall    = !scl_s && scl_p_q;
   assign start_det   = scl_s && scl_p_q && sda_p_q && !sda_s; // R6
   assign stop_det    = scl_s && scl_p_q && !sda_p_q && sda_s; // R11

   // ==========================================================
   // timeout counters
   logic [`SPS_CNT_W-1:0] low_cnt_q;
   logic [`SPS_CNT_W-1:0] idle_cnt_q;
   logic                 clklow_hit;
   logic                 idle_hit;

   assign clklow_hit = timeout_en_i &&
                       low_cnt_q == `SPS_CNT_W'(CLKLOW_CYC - 1); // R12
   // idle must exceed the limit, hence compare at the full count
   assign idle_hit   = timeout_en_i &&
                       idle_cnt_q == `SPS_CNT_W'(IDLE_CYC); // R13

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_q  <= '0;
         idle_cnt_q <= '0;
      end else begin
         if (!timeout_en_i || scl_s || clklow_hit) begin
            low_cnt_q <= '0;
         end else begin
            low_cnt_q <= low_cnt_q + `SPS_CNT_W'(1);
         end
         if (!timeout_en_i || !(scl_s && sda_s) || idle_hit) begin
            idle_cnt_q <= '0;
         end else begin
            idle_cnt_q <= idle_cnt_q + `SPS_CNT_W'(1);
         end
      end
   end

   // ==========================================================
   // slave state machine
   sps_state_type state_q;
   sps_state_type state_d;
   logic [3:0]    bitcnt_q;
   logic [3:0]    bitcnt_d;
   logic [7:0]    shift_q;
   logic [7:0]    shift_d;
   logic [7:0]    txsh_q;
   logic [7:0]    txsh_d;
   logic [7:0]    ptr_q;
   logic [7:0]    ptr_d;
   logic          drive_q;
   logic          drive_d;
   logic          rw_q;
   logic          rw_d;
   logic          first_q;
   logic          first_d;
   logic          ack_q;
   logic          ack_d;
   logic          mem_we;
   logic [7:0]    rdata;
   logic          abort;
   logic          byte_done;
   logic          addr_match;

   assign abort      = stop_det || clklow_hit || idle_hit ||
                       !twowire_sel || !ready_q; // R11 R12 R13 R24 R4
   assign byte_done  = scl_fall && (bitcnt_q == `SPS_BITS_PER_BYTE);
   assign addr_match = shift_q[7:1] == my_addr; // R7

   // deep sleep has no effect here; pointer forms stay best effort
   always_comb begin
      state_d  = state_q;
      bitcnt_d = bitcnt_q;
      shift_d  = shift_q;
      txsh_d   = txsh_q;
      ptr_d    = ptr_q;
      drive_d  = drive_q;
      rw_d     = rw_q;
      first_d  = first_q;
      ack_d    = ack_q;
      mem_we   = 1'b0;
      if (abort) begin
         state_d = ST_IDLE;
         drive_d = 1'b0;
      end else if (start_det) begin
         state_d  = ST_ADDR; // R6
         bitcnt_d = 4'h0;
         drive_d  = 1'b0;
         first_d  = 1'b1;
      end else begin
         case (state_q)
            ST_ADDR, ST_RX: begin
               if (scl_rise) begin
                  shift_d  = {shift_q[6:0], sda_s}; // R8
                  bitcnt_d = bitcnt_q + 4'h1;
               end else if (byte_done) begin
                  bitcnt_d = 4'h0;
                  if (state_q == ST_ADDR) begin
                     if (addr_match) begin
                        state_d = ST_ADDR_ACK;
                        drive_d = 1'b1; // R9
                        rw_d    = shift_q[0]; // R7
                     end else begin
                        state_d = ST_IGNORE; // R23
                     end
                  end else begin
                     state_d = ST_RX_ACK;
                     drive_d = 1'b1; // R9
                     first_d = 1'b0;
                     if (first_q) begin
                        ptr_d = shift_q; // R18 R16 R20
                     end else begin
                        mem_we = 1'b1; // R16 R21 R15
                        ptr_d  = ptr_q + `SPS_PTR_STEP; // R21
                     end
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (rw_q) begin
                     // pointer kept from earlier phase or frame
                     state_d  = ST_TX; // R17 R19
                     txsh_d   = rdata;
                     drive_d  = !rdata[7]; // R8
                     bitcnt_d = 4'h1;
                  end else begin
                     state_d  = ST_RX;
                     drive_d  = 1'b0;
                     bitcnt_d = 4'h0;
                  end
               end
            end
            ST_RX_ACK: begin
               if (scl_fall) begin
                  state_d  = ST_RX;
                  drive_d  = 1'b0;
                  bitcnt_d = 4'h0;
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bitcnt_q == `SPS_BITS_PER_BYTE) begin
                     state_d = ST_TX_ACK;
                     drive_d = 1'b0;
                     ptr_d   = ptr_q + `SPS_PTR_STEP; // R22
                  end else begin
                     txsh_d   = {txsh_q[6:0], 1'b0};
                     drive_d  = !txsh_q[6]; // R8
                     bitcnt_d = bitcnt_q + 4'h1;
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) begin
                  ack_d = !sda_s; // R10
               end else if (scl_fall) begin
                  if (ack_q) begin
                     state_d  = ST_TX; // R22 R15
                     txsh_d   = rdata;
                     drive_d  = !rdata[7];
                     bitcnt_d = 4'h1;
                  end else begin
                     state_d = ST_IGNORE; // R22
                  end
               end
            end
            default: begin
               state_d = state_q;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q  <= ST_IDLE;
         bitcnt_q <= 4'h0;
         shift_q  <= 8'h00;
         txsh_q   <= 8'h00;
         ptr_q    <= `SPS_PTR_RESET;
         drive_q  <= 1'b0;
         rw_q     <= 1'b0;
         first_q  <= 1'b0;
         ack_q    <= 1'b0;
      end else begin
         state_q  <= state_d;
         bitcnt_q <= bitcnt_d;
         shift_q  <= shift_d;
         txsh_q   <= txsh_d;
         ptr_q    <= ptr_d;
         drive_q  <= drive_d;
         rw_q     <= rw_d;
         first_q  <= first_d;
         ack_q    <= ack_d;
      end
   end

   // ==========================================================
   // register space and write notification
   logic       wr_q;
   logic [7:0] waddr_q;
   logic [7:0] wdata_q;

   sps_regmem u_regmem (
      .clk_i   (ref_clk_i),
      .we_i    (mem_we),
      .waddr_i (ptr_q),
      .wdata_i (shift_q),
      .raddr_i (ptr_q),
      .rdata_o (rdata)
   );

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         wr_q    <= 1'b0;
         waddr_q <= 8'h00;
         wdata_q <= 8'h00;
      end else begin
         wr_q    <= mem_we;
         waddr_q <= ptr_q;
         wdata_q <= shift_q;
      end
   end

   // ==========================================================
   // outputs; open drain, so only a low is ever driven, never clock
   assign sda_o       = 1'b0; // R5
   assign sda_oe_o    = drive_q;
   assign proto_sel_o = proto_q;
   assign ready_o     = ready_q;
   assign busy_o      = state_q != ST_IDLE;
   assign ptr_o       = ptr_q;
   assign reg_wr_o    = wr_q;
   assign reg_waddr_o = waddr_q;
   assign reg_wdata_o = wdata_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n);

   chk_quiet_other_mode: assert property ( // R24
      !twowire_sel |=> !drive_q)
      else $error("data line driven outside two-wire mode");

   chk_hold_off_idle: assert property ( // R4
      !ready_q |=> state_q == ST_IDLE)
      else $error("slave left idle during power-up hold-off");

   chk_start_enters_addr: assert property ( // R6
      start_det && !abort |=> state_q == ST_ADDR && bitcnt_q == 4'h0)
      else $error("start not followed by address phase");

   chk_stop_to_idle: assert property ( // R11
      stop_det |=> state_q == ST_IDLE && !drive_q)
      else $error("stop did not return slave to idle");

   chk_addr_ack: assert property ( // R9
      state_q == ST_ADDR && byte_done && addr_match && !abort
      |=> drive_q ##1 drive_q [*1] )
      else $error("matching address not acknowledged");

   chk_addr_nomatch: assert property ( // R23
      state_q == ST_ADDR && byte_done && !addr_match && !abort
      |=> state_q == ST_IGNORE && !drive_q)
      else $error("foreign address acknowledged");

   chk_ptr_load: assert property ( // R18
      state_q == ST_RX && byte_done && first_q && !abort
      |=> ptr_q == $past(shift_q) && !wr_q)
      else $error("first written byte did not load pointer");

   chk_write_incr: assert property ( // R21
      mem_we |=> wr_q && waddr_q == $past(ptr_q) &&
                 ptr_q == 8'($past(ptr_q) + `SPS_PTR_STEP))
      else $error("block write did not store and step pointer");

   chk_tx_msb: assert property ( // R8
      state_q == ST_ADDR_ACK && scl_fall && rw_q && !abort && !start_det
      |=> state_q == ST_TX && drive_q == !$past(rdata[7]))
      else $error("read byte not started with its top bit");

   chk_clklow_reset: assert property ( // R12
      clklow_hit |=> state_q == ST_IDLE ##1 low_cnt_q <= `SPS_CNT_W'(1))
      else $error("clock-low timeout did not reset the port");

   chk_nack_ends: assert property ( // R22
      state_q == ST_TX_ACK && scl_fall && !ack_q && !abort && !start_det
      |=> state_q == ST_IGNORE && !drive_q)
      else $error("read continued after host nack");

endmodule

// file: verilog/sps_defines.svh
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

// ==========================================================
// clock and timing
`define SPS_CLK_MHZ        200
`define SPS_POWERUP_MS     15
`define SPS_POWERUP_CYC    (`SPS_POWERUP_MS * 1000 * `SPS_CLK_MHZ)
`define SPS_CLKLOW_MS      30
`define SPS_CLKLOW_CYC     (`SPS_CLKLOW_MS * 1000 * `SPS_CLK_MHZ)
`define SPS_IDLE_US        200
`define SPS_IDLE_CYC       (`SPS_IDLE_US * `SPS_CLK_MHZ)
`define SPS_CNT_W          23

// ==========================================================
// byte framing
`define SPS_BITS_PER_BYTE  4'h8
`define SPS_PTR_RESET      8'h00
`define SPS_PTR_STEP       8'h01

// ==========================================================
// strapped slave addresses
`define SPS_SADDR_82K      7'h2C
`define SPS_SADDR_100K     7'h2B
`define SPS_SADDR_120K     7'h2A
`define SPS_SADDR_150K     7'h29
`define SPS_SADDR_VDD      7'h28
`define SPS_SADDR_NONE     7'h7F

`endif

// file: verilog/sps_pkg.sv
package sps_pkg;

   // ==========================================================
   // slave states, gray coded along address, data, ack path
   typedef enum logic [2:0] {
      ST_IDLE     = 3'h0,
      ST_ADDR     = 3'h1,
      ST_ADDR_ACK = 3'h3,
      ST_RX       = 3'h2,
      ST_RX_ACK   = 3'h6,
      ST_TX       = 3'h7,
      ST_TX_ACK   = 3'h5,
      ST_IGNORE   = 3'h4
   } sps_state_type;

   // ==========================================================
   // strap resistor decode, as delivered by the strap comparator
   typedef enum logic [2:0] {
      STRAP_GND  = 3'h0,
      STRAP_56K  = 3'h1,
      STRAP_68K  = 3'h2,
      STRAP_82K  = 3'h3,
      STRAP_100K = 3'h4,
      STRAP_120K = 3'h5,
      STRAP_150K = 3'h6,
      STRAP_VDD  = 3'h7
   } sps_strap_type;

   typedef enum logic [1:0] {
      PROTO_SPI4    = 2'h0,
      PROTO_SPI3    = 2'h1,
      PROTO_RSVD    = 2'h2,
      PROTO_TWOWIRE = 2'h3
   } sps_proto_type;

endpackage

// file: verilog/sps_regmem.sv
`timescale 1ns/1ps

module sps_regmem (
   // clock
   input  wire logic       clk_i,
   // write port
   input  wire logic       we_i,
   input  wire logic [7:0] waddr_i,
   input  wire logic [7:0] wdata_i,
   // read port
   input  wire logic [7:0] raddr_i,
   output logic      [7:0] rdata_o
);

   logic [7:0] mem [0:255];

   // no reset on the array; contents are undefined until written
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      rdata_o <= mem[raddr_i];
   end

endmodule

// file: sim/sps_host_model.sv
`timescale 1ns/1ps

// ==========================================================
// two-wire bus master, paced by the link clock
module sps_host_model #(
   parameter int Q = 10
) (
   // link time base
   input  wire logic link_clk_i,
   // wired data line level
   input  wire logic sda_i,
   // bus drive
   output logic      scl_o,
   output logic      sda_oe_o
);
   // ten link cycles a quarter bit keeps the clock near 390 kHz
   initial begin
      scl_o    = 1'b1;
      sda_oe_o = 1'b0;
   end

   task automatic qw();
      repeat (Q) @(posedge link_clk_i);
   endtask

   // works from idle and from mid-frame, so it also repeats
   task automatic start();
      qw();
      sda_oe_o = 1'b0;
      qw();
      scl_o = 1'b1;
      qw();
      sda_oe_o = 1'b1;
      qw();
      scl_o = 1'b0;
   endtask

   task automatic stop();
      qw();
      sda_oe_o = 1'b1;
      qw();
      scl_o = 1'b1;
      qw();
      sda_oe_o = 1'b0;
      qw();
   endtask

   // leaves both lines high mid-frame
   task automatic idle_hi();
      qw();
      sda_oe_o = 1'b0;
      qw();
      scl_o = 1'b1;
   endtask

   // data set a quarter bit after the fall, sampled mid-high
   task automatic bit_io(input logic b, output logic r);
      qw();
      sda_oe_o = ~b;
      qw();
      scl_o = 1'b1;
      qw();
      r = sda_i;
      qw();
      scl_o = 1'b0;
   endtask

   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask

   task automatic rbyte(output logic [7:0] b, input logic nack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, b[i]);
      end
      bit_io(nack, r);
   endtask
endmodule

// file: sim/tb.sv
`timescale 1ns/1ps

module tb;
   import sps_pkg::*;
   localparam int unsigned CLKLOW = 1000;
   localparam int unsigned IDLE   = 1000;
   logic       ref_clk = 1'b0;
   logic       link_clk;
   logic       rstn;
   logic [2:0] strap;
   logic       tmo_en;
   logic       sleep_flag;
   logic       cs_n;
   logic       scl;
   logic       host_oe;
   wire        sda_w;
   logic       sda_o;
   logic       sda_oe;
   logic [1:0] proto;
   logic       ready;
   logic       busy;
   logic [7:0] ptr;
   logic       reg_wr;
   logic [7:0] reg_waddr;
   logic [7:0] reg_wdata;
   integer     seed = 34;
   int         failures = 0;
   int         compares = 0;
   logic [7:0] mem [256];
   logic [15:0] wrq [$];
   logic       oe_seen;
   logic [6:0] sa;
   logic [7:0] d;
   logic [7:0] rd;
   logic [7:0] ad;

   // pull-up on the data line
   assign sda_w = ~((sda_oe & ~sda_o) | host_oe);

   always #2.5 ref_clk = ~ref_clk;
   initial begin
      link_clk = 1'b0;
      #1.3;
      forever #32 link_clk = ~link_clk;
   end

   // chip select toggles freely; the slave must not care
   always @(posedge ref_clk) begin
      #1 cs_n <= 1'($random(seed));
   end

   always @(posedge ref_clk) begin
      if (reg_wr === 1'b1) wrq.push_back({reg_waddr, reg_wdata});
      if (sda_oe === 1'b1) oe_seen <= 1'b1;
   end

   sps_slave #(.POWERUP_CYC(64), .CLKLOW_CYC(CLKLOW), .IDLE_CYC(IDLE))
   u_sps_slave (
      .ref_clk_i(ref_clk), .rstn_i(rstn), .protocol_strap_input_i(strap),
      .timeout_en_i(tmo_en), .deepest_sleep_flag_i(sleep_flag),
      .spi_cs_n_i(cs_n), .twowire_clock_pin_i(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .proto_sel_o(proto),
      .ready_o(ready), .busy_o(busy), .ptr_o(ptr), .reg_wr_o(reg_wr),
      .reg_waddr_o(reg_waddr), .reg_wdata_o(reg_wdata));

   sps_host_model u_sps_host_model (
      .link_clk_i(link_clk), .sda_i(sda_w), .scl_o(scl),
      .sda_oe_o(host_oe));

   function automatic logic [6:0] exp_addr(input logic [2:0] s);
      case (s)
         3'h3:    return 7'h2C;
         3'h4:    return 7'h2B;
         3'h5:    return 7'h2A;
         3'h6:    return 7'h29;
         default: return 7'h28;
      endcase
   endfunction

   function automatic logic [7:0] exp_proto(input logic [2:0] s);
      return (s > 3'h2) ? 8'h03 : {5'h00, s};
   endfunction

   task automatic end_sim();
      if (failures == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wb(input logic [7:0] b, input logic e);
      logic a;
      u_sps_host_model.wbyte(b, a);
      chk("ack", {7'h00, e}, {7'h00, a});
   endtask

   task automatic chk_wr(input logic [7:0] a, input logic [7:0] v);
      logic [15:0] w;
      w = (wrq.size() > 0) ? wrq.pop_front() : 16'hXXXX;
      chk("waddr", a, w[15:8]);
      chk("wdata", v, w[7:0]);
   endtask

   task automatic clk_n(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic do_reset(input logic [2:0] s);
      clk_n(1);
      rstn = 1'b0;
      strap = s;
      tmo_en = 1'b0;
      clk_n(20);
      chk("rst_oe", 8'h00, {7'h00, sda_oe});
      chk("rst_proto", 8'h02, {6'h00, proto});
      rstn = 1'b1;
      clk_n(10);
      chk("early_ready", 8'h00, {7'h00, ready});
      for (int i = 0; i < 200 && ready !== 1'b1; i++) clk_n(1);
      chk("ready", 8'h01, {7'h00, ready});
      chk("proto", exp_proto(s), {6'h00, proto});
      sa = exp_addr(s);
      wrq.delete();
   endtask

   initial begin
      repeat (200000) @(posedge ref_clk);
      failures++;
      end_sim();
   end

   initial begin
      rstn = 1'b0;
      strap = 3'h0;
      tmo_en = 1'b0;
      sleep_flag = 1'b0;
      cs_n = 1'b1;
      oe_seen = 1'b0;
      do_reset(3'(32'($unsigned($random(seed))) % 5) + 3'h3);
      // ==========================================================
      // single write
      d = 8'($random(seed));
      mem[1] = d;
      u_sps_host_model.start();
      wb({sa, 1'b0}, 1'b1);
      wb(8'h01, 1'b1);
      wb(d, 1'b1);
      chk_wr(8'h01, d);
      u_sps_host_model.stop();
      clk_n(10);
      chk("busy_stop", 8'h00, {7'h00, busy});
      // ==========================================================
      // block write across the wrap, deep sleep set
      sleep_flag = 1'b1;
      u_sps_host_model.start();
      wb({sa, 1'b0}, 1'b1);
      wb(8'hFF, 1'b1);
      for (int i = 0; i < 2; i++) begin
         d = 8'($random(seed));
         ad = 8'hFF + 8'(i);
         mem[ad] = d;
         wb(d, 1'b1);
         chk_wr(ad, d);
      end
      u_sps_host_model.stop();
      sleep_flag = 1'b0;
      chk("ptr_wrap", 8'h01, ptr);
      // ==========================================================
      // block read after repeated start
      u_sps_host_model.start();
      wb({sa, 1'b0}, 1'b1);
      wb(8'hFF, 1'b1);
      u_sps_host_model.start();
      wb({sa, 1'b1}, 1'b1);
      for (int i = 0; i < 3; i++) begin
         ad = 8'hFF + 8'(i);
         u_sps_host_model.rbyte(rd, i == 2);
         chk("rdata", mem[ad], rd);
      end
      u_sps_host_model.stop();
      // ==========================================================
      // pointer-only write, then read at the pointer
      u_sps_host_model.start();
      wb({sa, 1'b0}, 1'b1);
      wb(8'h00, 1'b1);
      u_sps_host_model.stop();
      chk("no_write", 8'h00, 8'(wrq.size()));
      chk("ptr_load", 8'h00, ptr);
      u_sps_host_model.start();
      wb({sa, 1'b1}, 1'b1);
      u_sps_host_model.rbyte(rd, 1'b1);
      chk("rdata_ptr", mem[0], rd);
      u_sps_host_model.stop();
      // ==========================================================
      // foreign address, rest of frame ignored
      u_sps_host_model.start();
      wb({sa ^ 7'h01, 1'b0}, 1'b0);
      wb(8'h00, 1'b0);
      u_sps_host_model.stop();
      // ==========================================================
      // timeouts
      tmo_en = 1'b1;
      u_sps_host_model.start();
      wb({sa, 1'b0}, 1'b1);
      chk("busy_low", 8'h01, {7'h00, busy});
      clk_n(CLKLOW + 50);
      chk("busy_clklow", 8'h00, {7'h00, busy});
      u_sps_host_model.stop();
      u_sps_host_model.start();
      wb({sa, 1'b0}, 1'b1);
      u_sps_host_model.idle_hi();
      chk("busy_high", 8'h01, {7'h00, busy});
      clk_n(IDLE + 50);
      chk("busy_idle", 8'h00, {7'h00, busy});
      // ==========================================================
      // non two-wire straps stay off the bus
      for (int s = 0; s < 3; s++) begin
         do_reset(3'(s));
         oe_seen = 1'b0;
         u_sps_host_model.start();
         wb({7'h28, 1'b0}, 1'b0);
         u_sps_host_model.stop();
         chk("oe_seen", 8'h00, {7'h00, oe_seen});
      end
      end_sim();
   end
endmodule
